// *** hdl/link_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module link_sync (
   input  wire logic sys_clk_i,
   input  wire logic srst_i,
   input  wire logic d_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   // Two stages plus one for edge history
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sync_state_s;

   sync_state_s r_reg;  // Registered state
   sync_state_s r_next; // Next state

   // Shift the pin through the chain
   always_comb begin
      r_next    = r_reg;
      r_next.s1 = d_i;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
   end

   // Idle high like a serial line
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         r_reg <= 3'h7;
      end else begin
         r_reg <= r_next;
      end
   end

   assign level_o = r_reg.s2;
   assign rise_o  = r_reg.s2 & ~r_reg.s3;
   assign fall_o  = ~r_reg.s2 & r_reg.s3;
endmodule // link_sync
`default_nettype wire

// *** hdl/serial_ctrl_gate.sv ***
`timescale 1ns/10ps
`default_nettype none
module serial_ctrl_gate
   import serial_ctrl_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   input  wire logic        module_standby_i,
   input  wire logic        standby_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        tx_fifo_write_i,
   input  wire logic        tx_dma_write_i,
   input  wire logic        tx_above_trig_i,
   input  wire logic        tx_low_evt_i,
   input  wire logic        tx_last_bit_i,
   input  wire logic        tx_fifo_empty_i,
   input  wire logic        tx_bit_i,
   input  wire logic        rx_frame_i,
   input  wire logic        rx_addr_bit_i,
   input  wire logic        rx_above_trig_i,
   input  wire logic        rx_overrun_evt_i,
   input  wire logic        rx_framing_evt_i,
   input  wire logic        rx_parity_evt_i,
   input  wire logic        rx_break_evt_i,
   input  wire logic        rx_ready_evt_i,
   input  wire logic        rx_fifo_read_i,
   input  wire logic        baud_clk_i,
   input  wire logic        rxd_i,
   input  wire logic        sck_i,
   output logic             txd_o,
   output logic             sck_o,
   output logic             sck_oe_o,
   output logic             tx_en_o,
   output logic             rx_en_o,
   output logic             tx_start_o,
   output logic             rx_start_o,
   output logic             rx_push_o,
   output logic             ser_clk_edge_o,
   output logic             tx_fifo_low_irq_o,
   output logic             rx_fifo_full_irq_o,
   output logic             rx_error_irq_o,
   output logic             tx_done_irq_o
);
   import serial_ctrl_pkg::*;

   // Whole state of the block
   typedef struct packed {
      logic [7:0]  ctrl;     // Serial control register
      logic [8:0]  mode;     // Mode bits this block needs
      logic        stall;    // Bus waitrequest
      logic [31:0] rdata;    // Bus read data
      logic        tx_done;  // Transmit done flag
      logic        framing;  // Framing error flag
      logic        parity;   // Parity error flag
      logic        addr_bit; // Last address bit seen
      logic        re_d;     // Receive enable, one cycle late
      logic        txd;      // Data pin level
      logic        sck;      // Clock pin level
      logic        sck_oe;   // Clock pin drive
      logic        tx_en;    // Transmitter enabled
      logic        rx_en;    // Receiver enabled
      logic        tx_start; // Transmit start pulse
      logic        rx_start; // Receive start pulse
      logic        rx_push;  // Frame to receive FIFO
      logic        clk_edge; // External clock edge pulse
      logic        irq_txl;  // Transmit low request
      logic        irq_rx;   // Receive request
      logic        irq_err;  // Receive error request
      logic        irq_done; // Transmit done request
   } top_state_s;

   localparam top_state_s STATE_RST = '{
      ctrl: CONTROL_RST, mode: MODE_RST, stall: 1'b1, rdata: 32'h0,
      tx_done: TX_DONE_RST, framing: 1'b0, parity: 1'b0,
      addr_bit: 1'b0, re_d: 1'b0, txd: 1'b1, sck: 1'b1,
      sck_oe: 1'b0, tx_en: 1'b0, rx_en: 1'b0, tx_start: 1'b0,
      rx_start: 1'b0, rx_push: 1'b0, clk_edge: 1'b0,
      irq_txl: 1'b0, irq_rx: 1'b0, irq_err: 1'b0, irq_done: 1'b0};

   top_state_s r_reg;  // Registered state
   top_state_s r_next; // Next state

   logic                 req;        // Any bus request
   logic                 take;       // Request completes this edge
   logic                 wr_status;  // Write to status register
   logic                 rd_status;  // Read of status register
   logic                 clr_all;    // Standby initialisation
   logic                 addr_wake_irq_enable_eff;   // Address wake in force
   logic                 wake_evt;   // Address frame ends wake
   logic                 sync_mode;  // Clocked synchronous mode
   logic [NUM_FLAGS-1:0] flg;        // Clearable flag values
   logic [NUM_FLAGS-1:0] flg_set;    // Flag set events
   logic [NUM_FLAGS-1:0] flg_cond;   // Extra clear conditions
   logic [NUM_FLAGS-1:0] flg_auto;   // Automatic clears
   logic [NUM_FLAGS-1:0] flg_hold;   // Freeze the flag
   logic [15:0]          status_w;   // Status word view
   logic                 rxd_fall;   // Start bit edge
   logic                 sck_rise;   // External clock edge
   logic                 cell_rst;   // Reset of flag cells

   // Bus handshake terms
   assign req       = avs_read_i | avs_write_i;
   assign take      = req & ~r_reg.stall;
   assign wr_status = take & avs_write_i & avs_byteenable_i[0]
                      & reg_hit(avs_address_i, OFS_STATUS);
   assign rd_status = take & avs_read_i
                      & reg_hit(avs_address_i, OFS_STATUS);
   assign clr_all   = module_standby_i | standby_i;
   assign cell_rst  = srst_i | clr_all;
   assign sync_mode = r_reg.mode[MODE_SYNC];

   // Address wake only for async address format
   assign addr_wake_irq_enable_eff = r_reg.ctrl[CTL_ADDR_WAKE]
                     & r_reg.mode[MODE_ADDR_FMT]
                     & ~sync_mode & ~r_reg.mode[MODE_IRDA];
   assign wake_evt = addr_wake_irq_enable_eff & rx_frame_i & rx_addr_bit_i;

   // Receive-side pins, two stages each
   link_sync u_rxd_sync (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .d_i       (rxd_i),
      .level_o   (),
      .rise_o    (),
      .fall_o    (rxd_fall)
   );

   link_sync u_sck_sync (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .d_i       (sck_i),
      .level_o   (),
      .rise_o    (sck_rise),
      .fall_o    ()
   );

   // Flag set, clear and hold terms; none depend on receive enable
   always_comb begin
      flg_set  = '0;
      flg_cond = '1;
      flg_auto = '0;
      flg_hold = '0;
      flg_set[FLG_TX_LOW]   = tx_low_evt_i;
      flg_cond[FLG_TX_LOW]  = tx_above_trig_i;
      flg_auto[FLG_TX_LOW]  = tx_dma_write_i & tx_above_trig_i;
      flg_hold[FLG_TX_LOW]  = ~r_reg.ctrl[CTL_TX_EN];
      flg_set[FLG_RX_LEVEL] = rx_above_trig_i & ~addr_wake_irq_enable_eff;
      flg_cond[FLG_RX_LEVEL] = ~rx_above_trig_i;
      flg_set[FLG_OVERRUN]  = rx_overrun_evt_i & ~addr_wake_irq_enable_eff;
      flg_set[FLG_BREAK]    = rx_break_evt_i;
      flg_set[FLG_READY]    = rx_ready_evt_i & ~addr_wake_irq_enable_eff;
      flg_set[FLG_FAULT]    = (rx_framing_evt_i | rx_parity_evt_i)
                              & ~addr_wake_irq_enable_eff;
   end

   // One cell per clearable flag
   genvar gi;
   generate
      for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
         status_flag_cell #(
            .RST (FLAGS_RST[gi])
         ) u_cell (
            .sys_clk_i  (sys_clk_i),
            .srst_i     (cell_rst),
            .set_i      (flg_set[gi]),
            .wr0_i      (wr_status & ~status_bit_of(gi)),
            .rd_i       (rd_status),
            .cond_i     (flg_cond[gi]),
            .auto_clr_i (flg_auto[gi]),
            .hold_i     (flg_hold[gi]),
            .flag_o     (flg[gi])
         );
      end
   endgenerate

   // Written bit of the status word for a flag slot
   function automatic logic status_bit_of(input int slot);
      unique case (slot)
         FLG_TX_LOW:   status_bit_of = avs_writedata_i[ST_TX_LOW];
         FLG_RX_LEVEL: status_bit_of = avs_writedata_i[ST_RX_LEVEL];
         FLG_OVERRUN:  status_bit_of = avs_writedata_i[ST_OVERRUN];
         FLG_BREAK:    status_bit_of = avs_writedata_i[ST_BREAK];
         FLG_READY:    status_bit_of = avs_writedata_i[ST_DATA_READY];
         default:      status_bit_of = avs_writedata_i[ST_FAULT];
      endcase
   endfunction

   // Status word as software sees it
   always_comb begin
      status_w                = 16'h0000;
      status_w[ST_TX_LOW]     = flg[FLG_TX_LOW];
      status_w[ST_RX_LEVEL]   = flg[FLG_RX_LEVEL];
      status_w[ST_OVERRUN]    = flg[FLG_OVERRUN];
      status_w[ST_FRAMING]    = r_reg.framing;
      status_w[ST_PARITY]     = r_reg.parity;
      status_w[ST_TX_DONE]    = r_reg.tx_done;
      status_w[ST_ADDR_BIT]   = r_reg.addr_bit;
      status_w[ST_DATA_READY] = flg[FLG_READY];
      status_w[ST_BREAK]      = flg[FLG_BREAK];
      status_w[ST_FAULT]      = flg[FLG_FAULT];
   end

   // Next state of the whole block
   always_comb begin
      r_next = r_reg;
      // One wait cycle, then the access completes
      r_next.stall = ~(req & r_reg.stall);
      if (req && r_reg.stall) begin
         r_next.rdata = 32'h0;        // Unmapped reads give zero
         if (avs_read_i && reg_hit(avs_address_i, OFS_CONTROL)) begin
            r_next.rdata = {24'h0, r_reg.ctrl};
         end else if (avs_read_i
                      && reg_hit(avs_address_i, OFS_MODE)) begin
            r_next.rdata = {23'h0, r_reg.mode};
         end else if (avs_read_i && reg_hit(avs_address_i,
                                            OFS_STATUS)) begin
            r_next.rdata = {16'h0, status_w};
         end
      end
      // Control writes, any time
      if (take && avs_write_i && avs_byteenable_i[0]
          && reg_hit(avs_address_i, OFS_CONTROL)) begin
         r_next.ctrl = avs_writedata_i[7:0];
      end
      // Mode writes, lane by lane
      if (take && avs_write_i && reg_hit(avs_address_i, OFS_MODE)) begin
         if (avs_byteenable_i[0]) begin
            r_next.mode[7:0] = avs_writedata_i[7:0];
         end
         if (avs_byteenable_i[1]) begin
            r_next.mode[MODE_IRDA] = avs_writedata_i[MODE_IRDA];
         end
      end
      // Address frame ends the wake wait
      if (wake_evt) begin
         r_next.ctrl[CTL_ADDR_WAKE] = 1'b0;
      end
      // Address bit tracks each frame in address format
      if (rx_frame_i && r_reg.mode[MODE_ADDR_FMT]) begin
         r_next.addr_bit = rx_addr_bit_i;
      end
      // Transmit done: FIFO write clears, end event sets
      if (tx_fifo_write_i) begin
         r_next.tx_done = 1'b0;
      end
      if (tx_last_bit_i && tx_fifo_empty_i) begin
         r_next.tx_done = 1'b1;
      end
      // Error flags follow the FIFO head; set wins
      if (rx_fifo_read_i) begin
         r_next.framing = 1'b0;
         r_next.parity  = 1'b0;
      end
      if (rx_framing_evt_i && !addr_wake_irq_enable_eff) begin
         r_next.framing = 1'b1;
      end
      if (rx_parity_evt_i && !addr_wake_irq_enable_eff) begin
         r_next.parity = 1'b1;
      end
      // Standby wipes control and mode
      if (clr_all) begin
         r_next.ctrl    = CONTROL_RST;
         r_next.mode    = MODE_RST;
         r_next.tx_done = TX_DONE_RST;
         r_next.framing = 1'b0;
         r_next.parity  = 1'b0;
         r_next.addr_bit = 1'b0;
      end
      // Engine enables, independent for full duplex
      r_next.tx_en = r_reg.ctrl[CTL_TX_EN];
      r_next.rx_en = r_reg.ctrl[CTL_RX_EN];
      r_next.re_d  = r_reg.ctrl[CTL_RX_EN];
      // Data line idles high while disabled
      r_next.txd = r_reg.ctrl[CTL_TX_EN] ? tx_bit_i : 1'b1;
      // Transmission starts on FIFO write
      r_next.tx_start = r_reg.ctrl[CTL_TX_EN] & tx_fifo_write_i;
      // Clock pin: drive only with internal clock
      if (r_reg.ctrl[CTL_CLK_EXT]) begin
         r_next.sck_oe = 1'b0;
      end else if (sync_mode) begin
         r_next.sck_oe = r_reg.ctrl[CTL_TX_EN]
                         | r_reg.ctrl[CTL_RX_EN];
      end else begin
         r_next.sck_oe = r_reg.ctrl[CTL_CLK_OUT];
      end
      r_next.sck      = r_next.sck_oe ? baud_clk_i : 1'b1;
      r_next.clk_edge = r_reg.ctrl[CTL_CLK_EXT] & sck_rise;
      // Reception start per mode
      r_next.rx_start = 1'b0;
      if (r_reg.ctrl[CTL_RX_EN]) begin
         if (!sync_mode) begin
            r_next.rx_start = rxd_fall;
         end else if (r_reg.ctrl[CTL_CLK_EXT]) begin
            r_next.rx_start = sck_rise;
         end else begin
            r_next.rx_start = ~r_reg.ctrl[CTL_TX_EN]
                              & ~r_reg.re_d;
         end
      end
      // Frames reach the FIFO unless waiting for an address
      r_next.rx_push = rx_frame_i & r_reg.ctrl[CTL_RX_EN]
                       & (~addr_wake_irq_enable_eff | rx_addr_bit_i);
      // Requests: flag AND enable, held as levels
      r_next.irq_txl  = r_reg.ctrl[CTL_TX_FIFO_IRQ_EN]
                        & flg[FLG_TX_LOW];
      r_next.irq_rx   = r_reg.ctrl[CTL_RX_IRQ_EN] & ~addr_wake_irq_enable_eff
                        & flg[FLG_RX_LEVEL];
      r_next.irq_err  = r_reg.ctrl[CTL_RX_IRQ_EN] & ~addr_wake_irq_enable_eff
                        & (flg[FLG_OVERRUN] | flg[FLG_BREAK]
                           | flg[FLG_READY] | flg[FLG_FAULT]);
      r_next.irq_done = r_reg.ctrl[CTL_TX_DONE_IRQ_EN]
                        & r_reg.tx_done;
   end

   // Register the state
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         r_reg <= STATE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from flops
   assign avs_readdata_o     = r_reg.rdata;
   assign avs_waitrequest_o  = r_reg.stall;
   assign txd_o              = r_reg.txd;
   assign sck_o              = r_reg.sck;
   assign sck_oe_o           = r_reg.sck_oe;
   assign tx_en_o            = r_reg.tx_en;
   assign rx_en_o            = r_reg.rx_en;
   assign tx_start_o         = r_reg.tx_start;
   assign rx_start_o         = r_reg.rx_start;
   assign rx_push_o          = r_reg.rx_push;
   assign ser_clk_edge_o     = r_reg.clk_edge;
   assign tx_fifo_low_irq_o  = r_reg.irq_txl;
   assign rx_fifo_full_irq_o = r_reg.irq_rx;
   assign rx_error_irq_o     = r_reg.irq_err;
   assign tx_done_irq_o      = r_reg.irq_done;

   AST_CTRL_STANDBY: assert property (@(posedge sys_clk_i)
      disable iff (srst_i)
      clr_all |=> r_reg.ctrl == CONTROL_RST ##1 !tx_en_o && !rx_en_o)
      else $error("control not cleared by standby");

   AST_BUS_ONE_WAIT: assert property (@(posedge sys_clk_i)
      disable iff (srst_i)
      req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer not after one wait cycle");

   AST_TXD_IDLE_HIGH: assert property (@(posedge sys_clk_i)
      disable iff (srst_i)
      !r_reg.ctrl[CTL_TX_EN] && !clr_all |=> txd_o)
      else $error("data line not high with transmit off");

   AST_TXL_IRQ: assert property (@(posedge sys_clk_i)
      disable iff (srst_i)
      ##1 tx_fifo_low_irq_o == $past(r_reg.ctrl[CTL_TX_FIFO_IRQ_EN]
                                     && flg[FLG_TX_LOW]))
      else $error("transmit low request not flag and enable");

   AST_RX_SUPPRESS: assert property (@(posedge sys_clk_i)
      disable iff (srst_i)
      addr_wake_irq_enable_eff && !rx_addr_bit_i |=> !rx_fifo_full_irq_o && !rx_push_o)
      else $error("receive activity during address wait");

   AST_WAKE_CLEAR: assert property (@(posedge sys_clk_i)
      disable iff (srst_i)
      wake_evt && !clr_all
      |=> !r_reg.ctrl[CTL_ADDR_WAKE] && r_reg.addr_bit)
      else $error("address frame did not end wake wait");

   AST_SCK_EXT_NO_DRIVE: assert property (@(posedge sys_clk_i)
      disable iff (srst_i)
      r_reg.ctrl[CTL_CLK_EXT] |=> !sck_oe_o)
      else $error("clock pin driven with external clock");

   AST_DONE_IRQ_DROP: assert property (@(posedge sys_clk_i)
      disable iff (srst_i)
      tx_fifo_write_i && !(tx_last_bit_i && tx_fifo_empty_i)
      |=> ##1 !tx_done_irq_o)
      else $error("transmit done request stayed after FIFO write");
endmodule // serial_ctrl_gate
`default_nettype wire

// *** hdl/serial_ctrl_pkg.sv ***
// Notes on behaviour
// - Control clears on reset and standby
// - Control is plain read/write at any time
// - Transmit low request when flag and enable
// - Transmit low request drops on clear
// - Receive interrupt enable gates receive and error requests
// - Receive requests drop after read-one-write-zero
// - Transmit disabled holds line high, flag frozen
// - Transmit starts when FIFO written
// - Receive disable leaves receive flags alone
// - Reception starts on start bit or clock
// - Internal synchronous clock starts with receive enable
// - Transmit and receive run together
// - Address wake works only in async address format
// - Address wake suppresses storing, receive requests and all receive flags except break
// - Address frame sets flag, clears wake enable
// - Transmit done request after last bit, empty
// - Transmit done drops on FIFO write
// - Clock select bits steer clock pin
// - Mode bit seven selects synchronous operation
// - Flag clear needs prior read of one
package serial_ctrl_pkg;
   // Register byte offsets
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_MODE    = 4'h4;
   localparam logic [3:0] OFS_STATUS  = 4'h8;
   // Reset values
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [8:0] MODE_RST    = 9'h000;
   // Control bit positions
   localparam int CTL_TX_FIFO_IRQ_EN = 7;
   localparam int CTL_RX_IRQ_EN      = 6;
   localparam int CTL_TX_EN          = 5;
   localparam int CTL_RX_EN          = 4;
   localparam int CTL_ADDR_WAKE      = 3;
   localparam int CTL_TX_DONE_IRQ_EN = 2;
   localparam int CTL_CLK_EXT        = 1;
   localparam int CTL_CLK_OUT        = 0;
   // Mode bit positions
   localparam int MODE_SYNC     = 7;
   localparam int MODE_ADDR_FMT = 2;
   localparam int MODE_IRDA     = 8;
   // Status bit positions
   localparam int ST_TX_LOW     = 7;
   localparam int ST_RX_LEVEL   = 6;
   localparam int ST_OVERRUN    = 5;
   localparam int ST_FRAMING    = 4;
   localparam int ST_PARITY     = 3;
   localparam int ST_TX_DONE    = 2;
   localparam int ST_ADDR_BIT   = 1;
   localparam int ST_DATA_READY = 8;
   localparam int ST_BREAK      = 9;
   localparam int ST_FAULT      = 10;
   // Clearable flag slots
   localparam int FLG_TX_LOW   = 0;
   localparam int FLG_RX_LEVEL = 1;
   localparam int FLG_OVERRUN  = 2;
   localparam int FLG_BREAK    = 3;
   localparam int FLG_READY    = 4;
   localparam int FLG_FAULT    = 5;
   localparam int NUM_FLAGS    = 6;
   localparam logic [5:0] FLAGS_RST   = 6'h01;
   localparam logic       TX_DONE_RST = 1'b1;

   // Word address match
   function automatic logic reg_hit(input logic [3:0] adr,
                                    input logic [3:0] ofs);
      reg_hit = (adr == ofs);
   endfunction
endpackage

// *** hdl/status_flag_cell.sv ***
`timescale 1ns/10ps
`default_nettype none
module status_flag_cell #(
   parameter logic RST = 1'b0
) (
   input  wire logic sys_clk_i,
   input  wire logic srst_i,
   input  wire logic set_i,
   input  wire logic wr0_i,
   input  wire logic rd_i,
   input  wire logic cond_i,
   input  wire logic auto_clr_i,
   input  wire logic hold_i,
   output logic      flag_o
);
   typedef struct packed {
      logic flag;  // Status flag
      logic armed; // Flag was read as one
   } cell_state_s;

   cell_state_s r_reg;
   cell_state_s r_next;

   // Read-arm, clear, set; set wins over clear
   always_comb begin
      r_next = r_reg;
      if (hold_i) begin
         r_next = r_reg;
      end else begin
         if (rd_i && r_reg.flag) begin
            r_next.armed = 1'b1;
         end
         if ((wr0_i && r_reg.armed && cond_i) || auto_clr_i) begin
            r_next.flag  = 1'b0;
            r_next.armed = 1'b0;
         end
         if (set_i) begin
            r_next.flag = 1'b1;
         end
      end
   end

   // Register the cell
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         r_reg <= {RST, 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign flag_o = r_reg.flag;

   AST_CLEAR_NEEDS_READ: assert property (@(posedge sys_clk_i)
      disable iff (srst_i)
      $fell(r_reg.flag) |-> $past(auto_clr_i) || $past(r_reg.armed)
                            || $past(srst_i))
      else $error("flag cleared without prior read of one");
endmodule // status_flag_cell
`default_nettype wire

// *** sim/serial_remote.sv ***
`timescale 1ns/10ps
`default_nettype none
module serial_remote (
   input  wire logic clk_i,
   output logic      rxd_o,
   output logic      sck_o
);
   // Line idles high, link clock stands still between frames
   initial begin
      rxd_o = 1'b1;
      sck_o = 1'b1;
   end
   // Start bit low, link clock of 160 ns, then back to idle
   task automatic frame();
      rxd_o <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         repeat (8) @(posedge clk_i);
         sck_o <= ~sck_o;
      end
      rxd_o <= 1'b1;
   endtask
endmodule // serial_remote
`default_nettype wire

// *** sim/tb_serial_ctrl_gate.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_serial_ctrl_gate;
   import serial_ctrl_pkg::*;
   // Bench-driven inputs, all defined at time zero
   logic sys_clk_i = 0, srst_i = 1, module_standby_i = 0, standby_i = 0;
   logic avs_read_i = 0, avs_write_i = 0, tx_fifo_write_i = 0;
   logic tx_dma_write_i = 0, tx_above_trig_i = 0, tx_low_evt_i = 0;
   logic tx_last_bit_i = 0, tx_fifo_empty_i = 1, tx_bit_i = 0;
   logic rx_frame_i = 0, rx_addr_bit_i = 0, rx_above_trig_i = 0;
   logic rx_overrun_evt_i = 0, rx_framing_evt_i = 0, rx_parity_evt_i = 0;
   logic rx_break_evt_i = 0, rx_ready_evt_i = 0, rx_fifo_read_i = 0;
   logic baud_clk_i = 0, rxd_i, sck_i;
   logic [3:0]  avs_address_i = 0, avs_byteenable_i = 4'h1;
   logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
   logic avs_waitrequest_o, txd_o, sck_o, sck_oe_o, tx_en_o, rx_en_o;
   logic tx_start_o, rx_start_o, rx_push_o, ser_clk_edge_o;
   logic tx_fifo_low_irq_o, rx_fifo_full_irq_o, rx_error_irq_o;
   logic tx_done_irq_o;
   int   error_cnt = 0, total_checks = 0, starts = 0, edges = 0;
   serial_ctrl_gate serial_ctrl_gate_inst (.*);
   serial_remote serial_remote_inst (.clk_i(sys_clk_i), .rxd_o(rxd_i),
      .sck_o(sck_i));
   always #5 sys_clk_i = ~sys_clk_i;
   // Count reception starts and external clock edges
   always @(posedge sys_clk_i) begin
      if (rx_start_o) starts <= starts + 1;
      if (ser_clk_edge_o) edges <= edges + 1;
   end
   // One bus cycle, held until waitrequest is sampled low
   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [31:0] r);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= ~w;
      avs_writedata_i <= {24'h0, d};
      do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
      r = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      // Idle edge keeps back-to-back strobes apart
      @(posedge sys_clk_i);
   endtask
   task automatic chk(input logic [31:0] e, s, input string nm);
      total_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      error_cnt++;
      give_verdict();
   end
   initial begin
      repeat (2) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      acc(0, OFS_CONTROL, 0, q);
      chk(0, q, "control reset");
      acc(1, OFS_MODE, 8'h00, q);
      acc(1, OFS_CONTROL, 8'ha5, q);
      acc(0, OFS_CONTROL, 0, q);
      chk(32'ha5, q, "control rw");
      chk(1, tx_done_irq_o, "tx done irq");
      chk(1, tx_en_o, "tx enable");
      chk(0, txd_o, "txd follows bit");
      chk(1, sck_oe_o, "sck async out");
      chk(0, sck_o, "sck level");
      tx_fifo_write_i <= 1'b1;
      @(posedge sys_clk_i) tx_fifo_write_i <= 1'b0;
      @(posedge sys_clk_i) chk(1, tx_start_o, "tx start");
      @(posedge sys_clk_i) chk(0, tx_done_irq_o, "tx done irq off");
      module_standby_i <= 1'b1;
      @(posedge sys_clk_i) module_standby_i <= 1'b0;
      acc(0, OFS_CONTROL, 0, q);
      chk(0, q, "control standby");
      chk(0, tx_en_o, "tx enable standby");
      $display("register test done");
      acc(1, OFS_CONTROL, 8'h80, q);
      repeat (3) @(posedge sys_clk_i);
      chk(1, tx_fifo_low_irq_o, "tx low irq");
      chk(1, txd_o, "txd idle");
      acc(1, OFS_CONTROL, 8'h00, q);
      repeat (3) @(posedge sys_clk_i);
      chk(0, tx_fifo_low_irq_o, "tx low irq off");
      $display("transmit test done");
      acc(1, OFS_CONTROL, 8'h50, q);
      rx_above_trig_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      chk(1, rx_fifo_full_irq_o, "rx irq");
      rx_above_trig_i <= 1'b0;
      acc(0, OFS_STATUS, 0, q);
      acc(1, OFS_STATUS, 8'h00, q);
      repeat (3) @(posedge sys_clk_i);
      chk(0, rx_fifo_full_irq_o, "rx irq cleared");
      serial_remote_inst.frame();
      repeat (5) @(posedge sys_clk_i);
      chk(1, starts, "rx start async");
      chk(0, edges, "no clock edge async");
      $display("receive test done");
      acc(1, OFS_MODE, 8'h04, q);
      acc(1, OFS_CONTROL, 8'h58, q);
      rx_frame_i <= 1'b1;
      rx_overrun_evt_i <= 1'b1;
      @(posedge sys_clk_i) rx_addr_bit_i <= 1'b1;
      rx_overrun_evt_i <= 1'b0;
      @(posedge sys_clk_i) rx_frame_i <= 1'b0;
      chk(0, rx_push_o, "push in wait");
      rx_overrun_evt_i <= 1'b1;
      @(posedge sys_clk_i) rx_overrun_evt_i <= 1'b0;
      chk(1, rx_push_o, "address frame pushed");
      chk(0, rx_error_irq_o, "error irq in wait");
      repeat (2) @(posedge sys_clk_i);
      chk(1, rx_error_irq_o, "error irq after wake");
      acc(0, OFS_CONTROL, 0, q);
      chk(32'h50, q, "wake enable cleared");
      rx_fifo_read_i <= 1'b1;
      @(posedge sys_clk_i) rx_fifo_read_i <= 1'b0;
      acc(0, OFS_STATUS, 0, q);
      chk(32'ha6, q, "status after wake");
      acc(1, OFS_STATUS, 8'h00, q);
      @(posedge sys_clk_i) chk(0, rx_error_irq_o, "error irq cleared");
      $display("wake test done");
      acc(1, OFS_CONTROL, 8'h00, q);
      acc(1, OFS_MODE, 8'h80, q);
      acc(1, OFS_CONTROL, 8'h10, q);
      @(posedge sys_clk_i) chk(1, sck_oe_o, "sck sync out");
      chk(1, rx_en_o, "rx enable");
      acc(1, OFS_CONTROL, 8'h02, q);
      acc(1, OFS_MODE, 8'h80, q);
      acc(1, OFS_CONTROL, 8'h12, q);
      serial_remote_inst.frame();
      repeat (5) @(posedge sys_clk_i);
      chk(10, starts, "rx starts sync");
      chk(8, edges, "external clock edges");
      chk(0, sck_oe_o, "sck input");
      $display("clock test done");
      give_verdict();
   end
endmodule // tb_serial_ctrl_gate
`default_nettype wire
